// *** core/dmi_pkg.sv ***
// Shared constants and types for the DRAM power-up and mode register block.
// Assumes the command pins are sampled on clk_sys, the device's own clock.
package dmi_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SELF_INIT_US = 500;
  localparam int SELF_INIT_CYC = (SELF_INIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MOD_CYC = 12;   // Settings update delay after a mode write, clocks
  localparam int DLLK_CYC = 512; // DLL lock time, clocks
  localparam int ZQINIT_CYC = 512; // Initial calibration time, clocks
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // Address and bank fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int BA_W = 3;
  localparam int MR_COUNT = 4;
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  localparam logic [2:0] BA_MR3 = 3'h3;
  localparam int BIT_DLL_DIS = 0;  // MR1, low enables the DLL
  localparam int BIT_CL0 = 2;      // MR0 latency low bit
  localparam int BIT_CL_HI = 4;    // MR0 latency upper field A6..A4
  localparam int BIT_AL = 3;       // MR1 additive latency A4..A3
  localparam int BIT_DLL_RST = 8;  // MR0, self-clearing
  localparam int BIT_WR = 9;       // MR0 write recovery A11..A9
  localparam int BIT_ZQ_LONG = 10;
  localparam int RTT_B0 = 2;
  localparam int RTT_B1 = 6;
  localparam int RTT_B2 = 9;
  localparam logic [ADDR_W-1:0] MR_RESET_VAL = 15'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic odt;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } dmi_cmd_t;

  typedef struct packed {
    logic [4:0] casLat;
    logic [4:0] addLat;
    logic [5:0] readLat;
    logic [4:0] wrRecov;
    logic [2:0] rttNom;
    logic dllOn;
  } dmi_set_t;

  typedef enum logic [5:0] {
    ST_RST = 6'h01,
    ST_SELF = 6'h02,
    ST_CKE = 6'h04,
    ST_MRS = 6'h08,
    ST_CAL = 6'h10,
    ST_READY = 6'h20
  } dmi_state_t;

endpackage : dmi_pkg

// *** core/dmi_mode_regs.sv ***
// Storage for the four mode registers, one full word per write.
// Assumes the owner serialises writes and the DLL reset clear strobe.
`timescale 1ns/1ps
`default_nettype none
module dmi_mode_regs #(
  parameter int DEPTH = dmi_pkg::MR_COUNT,
  parameter int WIDTH = dmi_pkg::ADDR_W
) (
  input wire logic clk_sys,                       // Device clock
  input wire logic resetn,                        // Sync reset, active low
  input wire logic wrEn,                          // Write whole word
  input wire logic [$clog2(DEPTH)-1:0] wrIdx,     // Register selected by bank bits
  input wire logic [WIDTH-1:0] wrData,            // New word
  input wire logic clrDllRst,                     // Self-clear of DLL reset bit
  output logic [DEPTH-1:0][WIDTH-1:0] contents    // Registered contents
);

  logic [DEPTH-1:0][WIDTH-1:0] mem_d;
  logic [DEPTH-1:0][WIDTH-1:0] mem_q;

  // Next contents: whole-word rewrite, then DLL reset bit self-clear
  always_comb begin
    mem_d = mem_q;
    if (wrEn) begin
      mem_d[wrIdx] = wrData;
    end
    // A fresh MR0 write in the same cycle wins over the self-clear
    if (clrDllRst && !(wrEn && wrIdx == '0)) begin
      mem_d[0][dmi_pkg::BIT_DLL_RST] = 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mem_q <= '{default: dmi_pkg::MR_RESET_VAL};
    end else begin
      mem_q <= mem_d;
    end
  end

  assign contents = mem_q;

endmodule : dmi_mode_regs
`default_nettype wire

// *** core/dmi_init_seq.sv ***
// Device-side power-up, reset and mode register handling of the DRAM.
// Assumes command pins arrive on clk_sys; the reset pin is asynchronous.
// Notes on behaviour
// - Internal init runs 500us after reset release
// - Termination off in reset until CKE high
// - Bank bits select the mode register
// - Init MR1 enables DLL, MR0 resets DLL
// - Mode writes never touch array contents
// - New settings take effect after tMOD
// - CAS latency from A2, A6..A4; RL=AL+CL
// - DLL reset bit clears itself after use
`timescale 1ns/1ps
`default_nettype none
module dmi_init_seq #(
  parameter int SELF_INIT_CYC = dmi_pkg::SELF_INIT_CYC,
  parameter int MOD_CYC = dmi_pkg::MOD_CYC,
  parameter int DLLK_CYC = dmi_pkg::DLLK_CYC,
  parameter int ZQINIT_CYC = dmi_pkg::ZQINIT_CYC
) (
  input wire logic clk_sys,                 // Device clock
  input wire logic resetn,                  // Block reset, sync, active low
  input wire logic resetPinN,               // Reset pin, asynchronous, active low
  input wire dmi_pkg::dmi_cmd_t cmd,        // Command, address and ODT pins
  output dmi_pkg::dmi_set_t settings,       // Applied mode settings
  output logic termActive,                  // On-die termination enabled
  output logic selfInitDone,                // Internal init wait over
  output logic dllLocked,                   // DLL lock time elapsed
  output logic zqDone,                      // Calibration time elapsed
  output logic initDone,                    // Ready for normal operation
  output logic seqError                     // Init order or timing broken
);

  // ----------------------------------------------------------------
  // Reset pin synchroniser
  // ----------------------------------------------------------------
  logic [2:0] pinSync_d;
  logic [2:0] pinSync_q;
  logic pinHigh_d;
  logic pinHigh_q;

  // Three stages; level changes once the second and third agree
  always_comb begin
    pinSync_d = {pinSync_q[1:0], resetPinN};
    pinHigh_d = pinHigh_q;
    if (pinSync_q[1] == pinSync_q[2]) begin
      pinHigh_d = pinSync_q[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pinSync_q <= 3'h0;
      pinHigh_q <= 1'b0;
    end else begin
      pinSync_q <= pinSync_d;
      pinHigh_q <= pinHigh_d;
    end
  end

  // ----------------------------------------------------------------
  // Command decode and field helpers
  // ----------------------------------------------------------------
  logic selCmd;
  logic isMrs;
  logic isZqcl;
  logic isIdle;

  assign selCmd = cmd.cke && !cmd.csN;
  assign isMrs = selCmd && !cmd.rasN && !cmd.casN && !cmd.weN;
  assign isZqcl = selCmd && cmd.rasN && cmd.casN && !cmd.weN
                  && cmd.addr[dmi_pkg::BIT_ZQ_LONG];
  assign isIdle = cmd.csN || (cmd.rasN && cmd.casN && cmd.weN);

  // CAS latency: {A6,A5,A4} + 4, plus 8 when A2 is set
  function automatic logic [4:0] decodeCl(input logic [dmi_pkg::ADDR_W-1:0] mr);
    logic [4:0] base;
    base = {2'h0, mr[dmi_pkg::BIT_CL_HI +: 3]} + 5'h04;
    decodeCl = mr[dmi_pkg::BIT_CL0] ? base + 5'h08 : base;
  endfunction : decodeCl

  // Write recovery clocks from A11..A9
  function automatic logic [4:0] decodeWr(input logic [2:0] code);
    unique case (code)
      3'h0: decodeWr = 5'h10;
      3'h1: decodeWr = 5'h05;
      3'h2: decodeWr = 5'h06;
      3'h3: decodeWr = 5'h07;
      3'h4: decodeWr = 5'h08;
      3'h5: decodeWr = 5'h0A;
      3'h6: decodeWr = 5'h0C;
      3'h7: decodeWr = 5'h0E;
    endcase
  endfunction : decodeWr

  // ----------------------------------------------------------------
  // Mode register storage
  // ----------------------------------------------------------------
  logic [dmi_pkg::MR_COUNT-1:0][dmi_pkg::ADDR_W-1:0] mrWords;
  logic mrWrEn;
  logic clrDllRst;
  dmi_pkg::dmi_state_t state_d;
  dmi_pkg::dmi_state_t state_q;

  // Writes only change mode words, never array state
  assign mrWrEn = isMrs && (state_q == dmi_pkg::ST_MRS || state_q == dmi_pkg::ST_READY);

  dmi_mode_regs uModeRegs (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wrEn(mrWrEn),
    .wrIdx(cmd.ba[1:0]),
    .wrData(cmd.addr),
    .clrDllRst(clrDllRst),
    .contents(mrWords)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [dmi_pkg::CNT_W-1:0] selfCnt_d, selfCnt_q;
  logic [dmi_pkg::CNT_W-1:0] modCnt_d, modCnt_q;
  logic [dmi_pkg::CNT_W-1:0] dllCnt_d, dllCnt_q;
  logic [dmi_pkg::CNT_W-1:0] zqCnt_d, zqCnt_q;
  logic [2:0] step_d, step_q;
  logic err_d, err_q;
  logic dllRun_d, dllRun_q;
  logic zqRun_d, zqRun_q;
  logic [2:0] expBa;

  // Expected bank code for each init step
  always_comb begin
    unique case (step_q)
      3'h0: expBa = dmi_pkg::BA_MR2;
      3'h1: expBa = dmi_pkg::BA_MR3;
      3'h2: expBa = dmi_pkg::BA_MR1;
      default: expBa = dmi_pkg::BA_MR0;
    endcase
  end

  // Next state, counters and error flag
  always_comb begin
    state_d = state_q;
    selfCnt_d = selfCnt_q;
    modCnt_d = (modCnt_q != '0) ? modCnt_q - 1'b1 : modCnt_q;
    dllCnt_d = (dllCnt_q != '0) ? dllCnt_q - 1'b1 : dllCnt_q;
    zqCnt_d = (zqCnt_q != '0) ? zqCnt_q - 1'b1 : zqCnt_q;
    step_d = step_q;
    err_d = err_q;
    dllRun_d = dllRun_q;
    zqRun_d = zqRun_q;
    clrDllRst = 1'b0;
    // Mode write applies after the update delay
    if (mrWrEn) begin
      modCnt_d = dmi_pkg::CNT_W'(MOD_CYC);
    end
    // DLL reset requested in MR0 starts the lock timer, then self-clears
    if (mrWords[0][dmi_pkg::BIT_DLL_RST]) begin
      clrDllRst = 1'b1;
      dllCnt_d = dmi_pkg::CNT_W'(DLLK_CYC);
      dllRun_d = 1'b1;
    end
    unique case (state_q)
      dmi_pkg::ST_RST: begin
        step_d = 3'h0;
        dllRun_d = 1'b0;
        zqRun_d = 1'b0;
        if (pinHigh_q) begin
          selfCnt_d = dmi_pkg::CNT_W'(SELF_INIT_CYC);
          state_d = dmi_pkg::ST_SELF;
        end
      end
      dmi_pkg::ST_SELF: begin
        selfCnt_d = selfCnt_q - 1'b1;
        if (cmd.cke) begin
          err_d = 1'b1;
        end
        if (selfCnt_q == dmi_pkg::CNT_W'(1)) begin
          state_d = dmi_pkg::ST_CKE;
        end
      end
      dmi_pkg::ST_CKE: begin
        if (cmd.cke) begin
          state_d = dmi_pkg::ST_MRS;
        end
      end
      dmi_pkg::ST_MRS: begin
        if (!cmd.cke || (!isIdle && !isMrs && !isZqcl)) begin
          err_d = 1'b1;
        end
        if (isMrs) begin
          if (cmd.ba != expBa || step_q == 3'h4) begin
            err_d = 1'b1;
          end
          if (cmd.ba == dmi_pkg::BA_MR1 && cmd.addr[dmi_pkg::BIT_DLL_DIS]) begin
            err_d = 1'b1;
          end
          if (cmd.ba == dmi_pkg::BA_MR0 && !cmd.addr[dmi_pkg::BIT_DLL_RST]) begin
            err_d = 1'b1;
          end
          step_d = step_q + 3'h1;
        end
        if (isZqcl) begin
          if (step_q != 3'h4) begin
            err_d = 1'b1;
          end
          zqCnt_d = dmi_pkg::CNT_W'(ZQINIT_CYC);
          zqRun_d = 1'b1;
          state_d = dmi_pkg::ST_CAL;
        end
      end
      dmi_pkg::ST_CAL: begin
        if (!cmd.cke || !isIdle) begin
          err_d = 1'b1;
        end
        if (dllRun_q && zqRun_q && dllCnt_q == '0 && zqCnt_q == '0) begin
          state_d = dmi_pkg::ST_READY;
        end
      end
      dmi_pkg::ST_READY: begin
        state_d = dmi_pkg::ST_READY;
      end
      default: begin
        state_d = dmi_pkg::ST_RST;
      end
    endcase
    // Reset pin low restarts the whole flow
    if (!pinHigh_q) begin
      state_d = dmi_pkg::ST_RST;
      err_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= dmi_pkg::ST_RST;
      selfCnt_q <= '0;
      modCnt_q <= '0;
      dllCnt_q <= '0;
      zqCnt_q <= '0;
      step_q <= 3'h0;
      err_q <= 1'b0;
      dllRun_q <= 1'b0;
      zqRun_q <= 1'b0;
    end else begin
      state_q <= state_d;
      selfCnt_q <= selfCnt_d;
      modCnt_q <= modCnt_d;
      dllCnt_q <= dllCnt_d;
      zqCnt_q <= zqCnt_d;
      step_q <= step_d;
      err_q <= err_d;
      dllRun_q <= dllRun_d;
      zqRun_q <= zqRun_d;
    end
  end

  // ----------------------------------------------------------------
  // Applied settings and status outputs
  // ----------------------------------------------------------------
  dmi_pkg::dmi_set_t set_d, set_q;
  logic term_d, term_q;
  logic [4:0] clNew;
  logic [4:0] alNew;

  // Decode settings when the update delay ends
  always_comb begin
    set_d = set_q;
    clNew = decodeCl(mrWords[0]);
    unique case (mrWords[1][dmi_pkg::BIT_AL +: 2])
      2'h1: alNew = clNew - 5'h01;
      2'h2: alNew = clNew - 5'h02;
      default: alNew = 5'h00;
    endcase
    if (modCnt_q == dmi_pkg::CNT_W'(1)) begin
      set_d.casLat = clNew;
      set_d.addLat = alNew;
      set_d.readLat = {1'b0, alNew} + {1'b0, clNew};
      set_d.wrRecov = decodeWr(mrWords[0][dmi_pkg::BIT_WR +: 3]);
      set_d.rttNom = {mrWords[1][dmi_pkg::RTT_B2], mrWords[1][dmi_pkg::RTT_B1],
                      mrWords[1][dmi_pkg::RTT_B0]};
      set_d.dllOn = !mrWords[1][dmi_pkg::BIT_DLL_DIS];
    end
    // Termination stays off until CKE is registered high
    term_d = 1'b0;
    if (state_q == dmi_pkg::ST_MRS || state_q == dmi_pkg::ST_CAL
        || state_q == dmi_pkg::ST_READY) begin
      term_d = cmd.odt && (set_q.rttNom != 3'h0) && pinHigh_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      set_q <= '0;
      term_q <= 1'b0;
    end else begin
      set_q <= set_d;
      term_q <= term_d;
    end
  end

  assign settings = set_q;
  assign termActive = term_q;
  assign selfInitDone = (state_q != dmi_pkg::ST_RST) && (state_q != dmi_pkg::ST_SELF);
  assign dllLocked = dllRun_q && (dllCnt_q == '0);
  assign zqDone = zqRun_q && (zqCnt_q == '0);
  assign initDone = (state_q == dmi_pkg::ST_READY);
  assign seqError = err_q;

endmodule : dmi_init_seq
`default_nettype wire

// *** verif/dmi_init_seq_properties.sv ***
// Checker for the DRAM power-up and mode register block.
// Assumes a bind into dmi_init_seq; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module dmi_init_seq_properties #(
  parameter int SELF_INIT_CYC = 20,
  parameter int MOD_CYC = 12,
  parameter int DLLK_CYC = 512,
  parameter int ZQINIT_CYC = 512
) (
  input wire logic clk_sys, // Device clock
  input wire logic resetn, // Block reset
  input wire logic resetPinN, // Reset pin
  input wire dmi_pkg::dmi_cmd_t cmd, // Command pins
  input wire dmi_pkg::dmi_set_t settings, // Applied settings
  input wire logic termActive, // Termination on
  input wire logic selfInitDone, // Self init over
  input wire logic dllLocked, // Lock time over
  input wire logic zqDone, // Calibration over
  input wire logic initDone, // Ready
  input wire logic seqError // Sticky error
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic mrs;
  logic zqcl;
  logic dllRst;
  logic [15:0] pinCnt_q;
  logic [15:0] mrsCnt_q;
  logic [15:0] zqCnt_q;
  logic [15:0] dllCnt_q;
  // Command decode of the sampled pins
  assign mrs = cmd.cke & ~cmd.csN & ~cmd.rasN & ~cmd.casN & ~cmd.weN;
  assign zqcl = cmd.cke & ~cmd.csN & cmd.rasN & cmd.casN & ~cmd.weN & cmd.addr[10];
  assign dllRst = mrs & (cmd.ba == 3'h0) & cmd.addr[8];
  function automatic logic [15:0] inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : inc
  // Clocks since pin release, mode write, calibration, DLL reset
  always_ff @(posedge clk_sys) begin
    pinCnt_q <= (!resetn || !resetPinN) ? 16'h0000 : inc(pinCnt_q);
    mrsCnt_q <= !resetn ? 16'hFFFF : (mrs ? 16'h0000 : inc(mrsCnt_q));
    zqCnt_q <= !resetn ? 16'hFFFF : (zqcl ? 16'h0000 : inc(zqCnt_q));
    dllCnt_q <= !resetn ? 16'hFFFF : (dllRst ? 16'h0000 : inc(dllCnt_q));
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_pinLow;
    !resetPinN [*6];
  endsequence
  property p_termCause;
    termActive |-> $past(cmd.odt) && ($past(settings.rttNom) != 3'h0);
  endproperty
  a_termCause: assert property (p_termCause) else $error("termination without cause");
  property p_pinHold;
    s_pinLow |-> !termActive && !selfInitDone && !initDone;
  endproperty
  a_pinHold: assert property (p_pinHold) else $error("active while pin low");
  property p_selfEarly;
    $rose(selfInitDone) |-> pinCnt_q >= SELF_INIT_CYC;
  endproperty
  a_selfEarly: assert property (p_selfEarly) else $error("self init too short");
  property p_selfLate;
    (pinCnt_q == SELF_INIT_CYC + 8) |-> selfInitDone;
  endproperty
  a_selfLate: assert property (p_selfLate) else $error("self init too long");
  property p_settle;
    (pinCnt_q >= 16'h0008) && $changed(settings) |-> mrsCnt_q >= 1 && mrsCnt_q <= MOD_CYC + 1;
  endproperty
  a_settle: assert property (p_settle) else $error("settings changed off time");
  property p_errSticky;
    (pinCnt_q >= 16'h0006) && seqError |=> seqError;
  endproperty
  a_errSticky: assert property (p_errSticky) else $error("error flag dropped");
  property p_readyTimers;
    $rose(initDone) |-> $past(dllLocked) && $past(zqDone);
  endproperty
  a_readyTimers: assert property (p_readyTimers) else $error("ready before timers");
  property p_readyState;
    $rose(selfInitDone) |-> !initDone && !dllLocked && !zqDone;
  endproperty
  a_readyState: assert property (p_readyState) else $error("timers running at self init end");
  property p_zqTime;
    $rose(zqDone) |-> zqCnt_q >= ZQINIT_CYC && zqCnt_q <= ZQINIT_CYC + 4;
  endproperty
  a_zqTime: assert property (p_zqTime) else $error("calibration time wrong");
  property p_dllTime;
    $rose(dllLocked) |-> dllCnt_q >= DLLK_CYC && dllCnt_q <= DLLK_CYC + 5;
  endproperty
  a_dllTime: assert property (p_dllTime) else $error("lock time wrong");
endmodule : dmi_init_seq_properties
bind dmi_init_seq dmi_init_seq_properties #(
  .SELF_INIT_CYC(SELF_INIT_CYC), .MOD_CYC(MOD_CYC), .DLLK_CYC(DLLK_CYC), .ZQINIT_CYC(ZQINIT_CYC)
) u_props (
  .clk_sys(clk_sys), .resetn(resetn), .resetPinN(resetPinN), .cmd(cmd),
  .settings(settings), .termActive(termActive), .selfInitDone(selfInitDone),
  .dllLocked(dllLocked), .zqDone(zqDone), .initDone(initDone), .seqError(seqError)
);
`default_nettype wire

// *** verif/dmi_ctrl_model.sv ***
// Behavioural memory controller for the power-up and mode flow.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
`default_nettype none
module dmi_ctrl_model #(
  parameter int MOD_CYC = 12
) (
  input wire logic clk_sys, // Device clock
  output var dmi_pkg::dmi_cmd_t cmd // Command and ODT pins
);
  // ----------------------------------------
  // Commands
  // ----------------------------------------
  localparam int MRD_CYC = 4; // Gap between mode writes
  logic ckeLvl = 1'b0; // Held CKE level
  logic odtLvl = 1'b1; // Held ODT level
  initial cmd = '0; // CKE low from time zero
  // One command for one clock, changed just after the edge
  task automatic issue(input logic [3:0] c, input logic [2:0] ba, input logic [14:0] a);
    @(posedge clk_sys);
    #2;
    cmd = {ckeLvl, c, odtLvl, ba, a};
  endtask : issue
  // NOP slots, address toggled so nothing stale is held
  task automatic idle(input int n);
    repeat (n) issue(4'h7, ~cmd.ba, ~cmd.addr);
  endtask : idle
  // Mode write, then the register cycle gap
  task automatic mrs(input logic [2:0] ba, input logic [14:0] a);
    issue(4'h0, ba, a);
    idle(MRD_CYC);
  endtask : mrs
  // Flow from CKE high up to the long calibration command
  task automatic init(input logic [14:0] mr1, input logic [14:0] mr0);
    odtLvl = 1'b0;
    idle(2); // Clock running, NOP registered
    ckeLvl = 1'b1;
    idle(6);
    mrs(3'h2, 15'h0000);
    mrs(3'h3, 15'h0000);
    mrs(3'h1, mr1 & 15'h7FFE); // DLL enabled
    mrs(3'h0, mr0 | 15'h0100); // DLL reset
    idle(MOD_CYC);
    issue(4'h6, 3'h0, 15'h0400); // Long calibration
  endtask : init
endmodule : dmi_ctrl_model
`default_nettype wire

// *** verif/dmi_init_seq_test.sv ***
// Self-checking bench for the DRAM power-up and mode block.
// Assumes dmi_ctrl_model drives the command pins.
`timescale 1ns/1ps
`default_nettype none
module dmi_init_seq_test;
  localparam int SELF_CYC = 20;
  localparam int MOD_CYC = dmi_pkg::MOD_CYC;
  localparam int LOCK_CYC = 16;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic resetPinN = 1'b0;
  dmi_pkg::dmi_cmd_t cmd;
  dmi_pkg::dmi_set_t settings;
  logic termActive, selfInitDone, dllLocked, zqDone, initDone, seqError;
  int err_total = 0;
  int checked = 0;
  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;
  dmi_ctrl_model u_ctrl (.clk_sys(clk_sys), .cmd(cmd));
  dmi_init_seq #(
    .SELF_INIT_CYC(SELF_CYC), .DLLK_CYC(LOCK_CYC), .ZQINIT_CYC(LOCK_CYC)
  ) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .resetPinN(resetPinN), .cmd(cmd),
    .settings(settings), .termActive(termActive), .selfInitDone(selfInitDone),
    .dllLocked(dllLocked), .zqDone(zqDone), .initDone(initDone), .seqError(seqError)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // NOPs until ready (0) or locked (1), bounded
  task automatic wait_for(input logic sel);
    int n;
    n = 0;
    while ((sel ? dllLocked : initDone) !== 1'b1 && n < 200) begin
      u_ctrl.idle(1);
      n++;
    end
    if ((sel ? dllLocked : initDone) !== 1'b1) begin
      err_total++;
      end_sim();
    end
  endtask : wait_for
  // Warm reset: CKE low first, pin low four clocks
  task automatic pin_reset(input int settle);
    u_ctrl.ckeLvl = 1'b0;
    u_ctrl.idle(1);
    resetPinN = 1'b0;
    u_ctrl.idle(4);
    resetPinN = 1'b1;
    u_ctrl.idle(settle);
  endtask : pin_reset
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_up;
    repeat (12) @(posedge clk_sys);
    #2;
    resetn = 1'b1;
    u_ctrl.idle(4000);
    chk(termActive, 1'b0);
    resetPinN = 1'b1;
    u_ctrl.idle(SELF_CYC + 10);
    chk({selfInitDone, termActive}, 2'h2);
    u_ctrl.init(15'h000D, 15'h0430);
    wait_for(1'b0);
    chk({seqError, settings}, {1'b0, 5'h07, 5'h06, 6'h0D, 5'h06, 3'h1, 1'h1});
    chk({zqDone, dllLocked}, 2'h3);
    u_ctrl.odtLvl = 1'b1;
    u_ctrl.idle(2);
    chk(termActive, 1'b1);
    u_ctrl.odtLvl = 1'b0;
  endtask : t_power_up
  // Every recovery code and A6..A4 latency code, then additive codes 0 to 2
  task automatic t_codes;
    logic [4:0] wrExp [8];
    int al;
    wrExp = '{5'h10, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h0E};
    for (int i = 0; i < 8; i++) begin
      u_ctrl.mrs(3'h0, {3'h0, 3'(i), 2'h0, 3'(i), 1'h0, 1'(i == 7), 2'h0});
      u_ctrl.idle(MOD_CYC);
      chk({settings.casLat, settings.wrRecov}, {5'(i + 4 + ((i == 7) ? 8 : 0)), wrExp[i]});
    end
    for (int j = 0; j < 3; j++) begin
      u_ctrl.mrs(3'h1, {10'h000, 2'(j), 3'h0});
      u_ctrl.idle(MOD_CYC);
      al = (j == 0) ? 0 : 19 - j;
      chk({settings.addLat, settings.readLat, settings.rttNom}, {5'(al), 6'(19 + al), 3'h0});
    end
  endtask : t_codes
  // Runtime DLL reset: lock drops, returns, ready stays
  task automatic t_dll_reset;
    u_ctrl.mrs(3'h0, 15'h0100);
    chk(dllLocked, 1'b0);
    wait_for(1'b1);
    chk({dllLocked, initDone, seqError}, 3'h6);
  endtask : t_dll_reset
  // Wrong first write, CKE early, then a clean warm reset
  task automatic t_faults;
    logic [2:0] bad [2];
    bad = '{3'h3, 3'h6};
    for (int i = 0; i < 2; i++) begin
      pin_reset(SELF_CYC + 10);
      chk(seqError, 1'b0);
      u_ctrl.ckeLvl = 1'b1;
      u_ctrl.idle(6);
      u_ctrl.mrs(bad[i], 15'h0000);
      chk(seqError, 1'b1);
    end
    pin_reset(8);
    u_ctrl.ckeLvl = 1'b1;
    u_ctrl.idle(2);
    chk(seqError, 1'b1);
    pin_reset(SELF_CYC + 10);
    u_ctrl.init(15'h000C, 15'h0430);
    wait_for(1'b0);
    chk({initDone, seqError, settings.casLat}, {1'b1, 1'b0, 5'h07});
    u_ctrl.odtLvl = 1'b1;
    u_ctrl.idle(2);
    chk(termActive, 1'b1);
    pin_reset(4);
    chk(termActive, 1'b0);
  endtask : t_faults
  // Main sequence
  initial begin
    t_power_up();
    t_codes();
    t_dll_reset();
    t_faults();
    end_sim();
  end
endmodule : dmi_init_seq_test
`default_nettype wire
